// >>> hdl/wfs_regs.vh
`ifndef WFS_REGS_VH
`define WFS_REGS_VH
`define WFS_CLK_MHZ          25
`define WFS_BASE_TIMEOUT_US  10000
`define WFS_BASE_TIMEOUT_CYC (`WFS_BASE_TIMEOUT_US * `WFS_CLK_MHZ)
`define WFS_FILT_DELAY_US    10
`define WFS_FILT_DELAY_CYC   (`WFS_FILT_DELAY_US * `WFS_CLK_MHZ)
`define WFS_ADDR_CTRL        3'h0
`define WFS_ADDR_OLC         3'h1
`define WFS_ADDR_OCC         3'h5
`define WFS_ADDR_TSC         3'h6
`define WFS_KICK_BIT         15
`define WFS_ADDR_HI          14
`define WFS_ADDR_LO          12
`define WFS_DIV_HI           5
`define WFS_DIV_LO           4
`define WFS_FAILSAFE_DRIVE   12'h005
`define WFS_CFG_RESET        12'h000
`define WFS_NUM_OUT          12
`define WFS_NUM_HS           4
`endif

// >>> hdl/wfs_supervisor.v
`timescale 1ns/1ps
`include "wfs_regs.vh"
module wfs_supervisor
#(
  parameter [17:0] BASE_TIMEOUT_CYC = `WFS_BASE_TIMEOUT_CYC
)
(
  input  wire        mclk,
  input  wire        rst_b,
  input  wire        wakeInput,
  input  wire        resetInput_b,
  input  wire        kickInput,
  input  wire        failsafeDisableInput,
  input  wire        lowsideDirectInput,
  input  wire [3:0]  highsideDirectInputs,
  input  wire        chipSelect_b,
  input  wire        serialClock,
  input  wire        serialIn,
  input  wire        overVoltageSense,
  input  wire [11:0] overTempSense,
  input  wire [11:0] openLoadSense,
  input  wire [7:0]  overCurrentSense,
  output reg         highDriver0,
  output reg         highDriver2,
  output reg  [1:0]  highDriversOdd,
  output reg  [7:0]  lowDrivers,
  output reg         faultFlagOutput_b,
  output reg         serialOut,
  output reg         serialOutEn_b,
  output reg         failsafeActive
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam SW = 45;
  wire [SW-1:0] pinsRaw;
  reg  [SW-1:0] sync1_r;
  reg  [SW-1:0] sync2_r;

  // Every pin passes two flip-flops before any logic reads it.
  assign pinsRaw = {wakeInput, resetInput_b, kickInput,
                    failsafeDisableInput, lowsideDirectInput,
                    highsideDirectInputs, chipSelect_b, serialClock,
                    serialIn, overVoltageSense, overTempSense,
                    openLoadSense, overCurrentSense};

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_r <= 45'h008_0000_0000; // Chip select idles high.
      sync2_r <= 45'h008_0000_0000; // No false select edge after reset.
    end
    else
    begin
      sync1_r <= pinsRaw;
      sync2_r <= sync1_r;
    end
  end

  wire        wake   = sync2_r[44];
  wire        rstIn  = sync2_r[43];
  wire        kickS  = sync2_r[42];
  wire        fsiS   = sync2_r[41];
  wire        lsDir  = sync2_r[40];
  wire [3:0]  hsDir  = sync2_r[39:36];
  wire        csS    = sync2_r[35];
  wire        sclkS  = sync2_r[34];
  wire        mosiS  = sync2_r[33];
  wire        ovS    = sync2_r[32];
  wire [11:0] otS    = sync2_r[31:20];
  wire [11:0] olS    = sync2_r[19:8];
  wire [7:0]  ocS    = sync2_r[7:0];

  // ---------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------
  reg wakePrev_r;
  reg rstPrev_r;
  reg kickPrev_r;
  reg csPrev_r;
  reg sclkPrev_r;

  // Previous values of the synchronised pins, for edge detection.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wakePrev_r <= 1'b0;
      rstPrev_r  <= 1'b0;
      kickPrev_r <= 1'b0;
      csPrev_r   <= 1'b1;
      sclkPrev_r <= 1'b0;
    end
    else
    begin
      wakePrev_r <= wake;
      rstPrev_r  <= rstIn;
      kickPrev_r <= kickS;
      csPrev_r   <= csS;
      sclkPrev_r <= sclkS;
    end
  end

  wire wakeRise = wake & ~wakePrev_r;
  wire rstRise  = rstIn & ~rstPrev_r;
  wire csFall   = ~csS & csPrev_r;
  wire csRise   = csS & ~csPrev_r;
  wire sclkRise = ~csS & sclkS & ~sclkPrev_r;
  wire sclkFall = ~csS & ~sclkS & sclkPrev_r;

  // ---------------------------------------------------------------
  // Serial frame and configuration
  // ---------------------------------------------------------------
  reg  [15:0] shift_r;
  reg  [3:0]  bitCnt_r;
  reg         anyBits_r;
  reg         kickBit_r;
  reg  [11:0] ctrlCfg_r;
  reg  [11:0] olCfg_r;
  reg  [7:0]  ocCfg_r;
  reg  [1:0]  divCfg_r;
  reg  [11:0] stat_r;
  wire        frameOk = csRise & anyBits_r & (bitCnt_r == 4'h0);
  wire [2:0]  addr    = shift_r[`WFS_ADDR_HI:`WFS_ADDR_LO];
  wire        bitKick = frameOk & (shift_r[`WFS_KICK_BIT] != kickBit_r);
  wire [2:0]  odMux   = kickBit_r ? {hsDir[2], hsDir[3], wake}
                                  : {hsDir[0], hsDir[1], fsiS};

  // Shift register loads status at chip-select fall, takes data on
  // clock rise; bits past sixteen echo the received bits.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_r   <= 16'h0000;
      bitCnt_r  <= 4'h0;
      anyBits_r <= 1'b0;
    end
    else if (csFall)
    begin
      shift_r   <= {kickBit_r, odMux, stat_r};
      bitCnt_r  <= 4'h0;
      anyBits_r <= 1'b0;
    end
    else if (sclkRise)
    begin
      shift_r   <= {shift_r[14:0], mosiS};
      bitCnt_r  <= bitCnt_r + 4'h1;
      anyBits_r <= 1'b1;
    end
  end

  // Configuration is applied at chip-select rise after a valid frame and
  // is held at zero while the reset input is low.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      kickBit_r <= 1'b0;
      ctrlCfg_r <= `WFS_CFG_RESET;
      olCfg_r   <= `WFS_CFG_RESET;
      ocCfg_r   <= 8'h00;
      divCfg_r  <= 2'h0;
    end
    else if (!rstIn)
    begin
      kickBit_r <= 1'b0;
      ctrlCfg_r <= `WFS_CFG_RESET;
      olCfg_r   <= `WFS_CFG_RESET;
      ocCfg_r   <= 8'h00;
      divCfg_r  <= 2'h0;
    end
    else if (frameOk)
    begin
      kickBit_r <= shift_r[`WFS_KICK_BIT];
      if (addr == `WFS_ADDR_CTRL)
        ctrlCfg_r <= shift_r[11:0];
      else if (addr == `WFS_ADDR_OLC)
        olCfg_r <= shift_r[11:0];
      else if (addr == `WFS_ADDR_OCC)
        ocCfg_r <= shift_r[11:4];
      else if (addr == `WFS_ADDR_TSC)
        divCfg_r <= shift_r[`WFS_DIV_HI:`WFS_DIV_LO];
    end
  end

  // Serial output drives only while chip select is low.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      serialOut     <= 1'b0;
      serialOutEn_b <= 1'b1;
    end
    else
    begin
      serialOutEn_b <= csS;
      if (csFall)
        serialOut <= kickBit_r;
      else if (sclkFall)
        serialOut <= shift_r[15];
    end
  end

  // ---------------------------------------------------------------
  // Watchdog and fail-safe
  // ---------------------------------------------------------------
  reg  [17:0] wdCnt_r;
  reg         wdEn_r;
  wire [17:0] wdLimit = BASE_TIMEOUT_CYC >> divCfg_r;
  wire        kick    = bitKick | (kickS ^ kickPrev_r);
  wire        fsiTied = ~fsiS;
  wire        expire  = wdEn_r & (wdCnt_r >= wdLimit - 18'h1);

  // Counter restarts on enable edges and kicks; expiry enters fail-safe
  // and both inputs low, or failsafeDisableInput low, take the device out again.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wdEn_r         <= 1'b0;
      wdCnt_r        <= 18'h00000;
      failsafeActive <= 1'b0;
    end
    else if (fsiTied)
    begin
      wdEn_r         <= 1'b0;
      wdCnt_r        <= 18'h00000;
      failsafeActive <= 1'b0;
    end
    else if (failsafeActive)
    begin
      wdCnt_r <= 18'h00000;
      if (!wake && !rstIn)
      begin
        failsafeActive <= 1'b0;
        wdEn_r         <= 1'b0;
      end
    end
    else if (wakeRise || rstRise)
    begin
      wdEn_r  <= 1'b1;
      wdCnt_r <= 18'h00000;
    end
    else if (kick)
      wdCnt_r <= 18'h00000;
    else if (expire && (wake || rstIn))
      failsafeActive <= 1'b1;
    else if (wdEn_r)
      wdCnt_r <= wdCnt_r + 18'h1;
  end

  // ---------------------------------------------------------------
  // Output commands and protection
  // ---------------------------------------------------------------
  wire [11:0] cmd = ctrlCfg_r | {{8{lsDir}}, hsDir};
  reg  [11:0] cmdPrev_r;
  reg  [11:0] drive_r;
  reg  [7:0]  lsOtOff_r;
  reg  [7:0]  lsOcOff_r;
  reg  [7:0]  lsFlag_r;
  wire [7:0]  lsCmd = cmd[11:4];
  wire [7:0]  lsOc;
  wire [7:0]  lsOl;

  // Per low-driver fault filter: overcurrent while on, open load off.
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : lsFilt
      reg  [7:0] cnt_r;
      wire       ocRaw = drive_r[g+4] & ocCfg_r[g] & ocS[g];
      wire       olRaw = ~lsCmd[g] & olCfg_r[g+4] & olS[g+4];
      wire       raw   = lsCmd[g] ? ocRaw : olRaw;
      wire       done  = (cnt_r == `WFS_FILT_DELAY_CYC);
      always @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
          cnt_r <= 8'h00;
        else if (!raw)
          cnt_r <= 8'h00;
        else if (!done)
          cnt_r <= cnt_r + 8'h1;
      end
      assign lsOc[g] = done & lsCmd[g];
      assign lsOl[g] = done & ~lsCmd[g];
    end
  endgenerate

  wire [7:0]  lsOt     = otS[11:4] & lsCmd;
  wire [3:0]  hsOt     = otS[3:0] & cmd[3:0];
  wire [3:0]  hsOl     = olS[3:0] & ~cmd[3:0] & ~olCfg_r[3:0];
  wire [7:0]  lsFault  = lsOt | lsOc | lsOl;
  wire [11:0] faultNow = {lsOtOff_r | lsOcOff_r | lsOl, hsOt | hsOl}
                         | {12{ovS}};
  wire [7:0]  lsToggle = lsCmd ^ cmdPrev_r[11:4];

  // Low-driver shutdown latches clear only once the output is commanded
  // off, so a cooled or retried output never restarts by itself.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmdPrev_r <= 12'h000;
      lsOtOff_r <= 8'h00;
      lsOcOff_r <= 8'h00;
      lsFlag_r  <= 8'h00;
    end
    else
    begin
      cmdPrev_r <= cmd;
      lsOtOff_r <= lsOt | (lsOtOff_r & lsCmd);
      lsOcOff_r <= lsOc | (lsOcOff_r & lsCmd);
      if (!rstIn)
        lsFlag_r <= 8'h00;
      else
        lsFlag_r <= lsFault | (lsFlag_r & ~lsToggle);
    end
  end

  // Status bits: a fault sets, chip-select rise clears; set wins.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      stat_r <= 12'h000;
    else
      stat_r <= faultNow | (stat_r & ~{12{csRise}});
  end

  // Output drive, in priority order: fail-safe, reset, overvoltage.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      drive_r <= 12'h000;
    else if (failsafeActive)
      drive_r <= `WFS_FAILSAFE_DRIVE;
    else if (!rstIn)
      drive_r <= 12'h000;
    else if (ovS)
      drive_r <= 12'h000;
    else
      drive_r <= {lsCmd & ~lsOtOff_r & ~lsOcOff_r & ~lsOt,
                  cmd[3:0] & ~otS[3:0]};
  end

  // Pin registers follow the drive vector; fault flag is active low.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      highDriver0       <= 1'b0;
      highDriver2       <= 1'b0;
      highDriversOdd    <= 2'h0;
      lowDrivers        <= 8'h00;
      faultFlagOutput_b <= 1'b1;
    end
    else
    begin
      highDriver0       <= drive_r[0];
      highDriver2       <= drive_r[2];
      highDriversOdd    <= {drive_r[3], drive_r[1]};
      lowDrivers        <= drive_r[11:4];
      faultFlagOutput_b <= ~(ovS | (|hsOt) | (|hsOl) | (|lsFlag_r));
    end
  end

endmodule

// >>> verification/wfs_checker_props.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checks for the supervisor
// ------------------------------------------------------------
module wfs_checker
(
  input wire       mclk,
  input wire       rst_b,
  input wire       wakeInput,
  input wire       resetInput_b,
  input wire       failsafeDisableInput,
  input wire       chipSelect_b,
  input wire       overVoltageSense,
  input wire       highDriver0,
  input wire       highDriver2,
  input wire [1:0] highDriversOdd,
  input wire [7:0] lowDrivers,
  input wire       faultFlagOutput_b,
  input wire       serialOutEn_b,
  input wire       failsafeActive
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // True when every output driver is off.
  wire allOff = !highDriver0 && !highDriver2 && highDriversOdd == 2'h0 &&
                lowDrivers == 8'h00;

  a_fs_drive: assert property (
    failsafeActive[*5] |-> highDriver0 && highDriver2 &&
    highDriversOdd == 2'h0 && lowDrivers == 8'h00)
    else $error("fail-safe drive pattern wrong");
  a_fs_hold: assert property (
    (resetInput_b && failsafeDisableInput)[*4] ##0 failsafeActive
    |=> failsafeActive) else $error("fail-safe left too early");
  a_fsi_block: assert property (
    !failsafeDisableInput[*5] |-> !failsafeActive)
    else $error("fail-safe while disabled");
  a_fs_exit: assert property (
    (!resetInput_b && !wakeInput)[*5] |-> !failsafeActive)
    else $error("fail-safe not left");
  a_rst_off: assert property (
    (!resetInput_b && !failsafeActive)[*6] |-> allOff)
    else $error("output on while held in reset");
  a_ov_off: assert property (
    overVoltageSense[*5] |-> lowDrivers == 8'h00 && highDriversOdd == 2'h0)
    else $error("output on during overvoltage");
  a_ov_flag: assert property (
    overVoltageSense[*5] |-> !faultFlagOutput_b)
    else $error("flag high during overvoltage");
  a_so_idle: assert property (
    chipSelect_b[*6] |-> serialOutEn_b)
    else $error("serial output driven while deselected");

  cover property ($rose(failsafeActive));
  cover property (overVoltageSense && !faultFlagOutput_b);
  cover property ($fell(chipSelect_b));
endmodule

bind wfs_supervisor wfs_checker wfs_checker_inst (.*);

// >>> verification/wfs_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host serial master model
// ------------------------------------------------------------
module wfs_host_model
(
  input  wire mclk,
  input  wire serialOut,
  output reg  chipSelect_b,
  output reg  serialClock,
  output reg  serialIn
);
  // The serial clock stands still low between frames.
  initial
  begin
    chipSelect_b = 1'b1;
    serialClock  = 1'b0;
    serialIn     = 1'b0;
  end

  // Sends the low n bits of tx MSB first, kick_bit leading only when n is 16, four mclk per half bit.
  task automatic xfer(input logic [15:0] tx, input int n,
                      output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    @(posedge mclk);
    #2 chipSelect_b = 1'b0;
    for (i = n - 1; i >= 0; i--)
    begin
      repeat (4) @(posedge mclk);
      #2 serialClock = 1'b0;
      serialIn = tx[i];
      repeat (4) @(posedge mclk);
      #2 serialClock = 1'b1;
      rx = {rx[14:0], serialOut};
    end
    repeat (4) @(posedge mclk);
    #2 serialClock = 1'b0;
    repeat (4) @(posedge mclk);
    #2 chipSelect_b = 1'b1;
    serialIn = ~serialIn; // Released line shows the inverse value.
    repeat (8) @(posedge mclk);
  endtask
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Supervisor testbench
// ------------------------------------------------------------
module testbench;
  reg         mclk, rst_b, wakeInput, resetInput_b, kickInput;
  reg         failsafeDisableInput, lowsideDirectInput, overVoltageSense;
  reg  [3:0]  highsideDirectInputs;
  reg  [11:0] overTempSense, openLoadSense;
  reg  [7:0]  overCurrentSense;
  wire        chipSelect_b, serialClock, serialIn, serialOut;
  wire        serialOutEn_b, highDriver0, highDriver2;
  wire        faultFlagOutput_b, failsafeActive;
  wire [1:0]  highDriversOdd;
  wire [7:0]  lowDrivers;
  logic [15:0] rx;
  int         compares = 0;
  int         miscompares = 0;
  int         cycles = 0;
  // All drivers packed in status-bit order.
  wire [11:0] outs = {lowDrivers, highDriversOdd[1], highDriver2,
                      highDriversOdd[0], highDriver0};

  wfs_supervisor #(.BASE_TIMEOUT_CYC(18'h100)) wfs_supervisor_inst (.*);
  wfs_host_model wfs_host_model_inst (.*);

  // Free-running 25 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Cuts a hang short.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end

  // Advances n edges and steps just past the last one.
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits a bounded time for fail-safe, returning the cycles taken.
  task waitFs(output int n);
    n = 0;
    while (failsafeActive !== 1'b1 && n < 1000)
    begin
      tick(1);
      n++;
    end
  endtask

  task tally_and_finish;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    int n;
    rst_b = 1'b0;
    {wakeInput, resetInput_b, kickInput, failsafeDisableInput} = 4'h0;
    {lowsideDirectInput, overVoltageSense} = 2'h0;
    highsideDirectInputs = 4'h0;
    {overTempSense, openLoadSense, overCurrentSense} = 32'h0;
    tick(2);
    rst_b = 1'b1;
    lowsideDirectInput = 1'b1;
    highsideDirectInputs = 4'hf;
    tick(8);
    chk("outs", 16'h0000, {4'h0, outs});
    resetInput_b = 1'b1;
    tick(8);
    chk("outs", 16'h0fff, {4'h0, outs});
    {lowsideDirectInput, highsideDirectInputs} = 5'h00;
    openLoadSense = 12'h001;
    tick(8);
    chk("flag", 16'h0000, 16'(faultFlagOutput_b));
    openLoadSense = 12'h000;
    tick(8);
    chk("flag", 16'h0001, 16'(faultFlagOutput_b));
    wfs_host_model_inst.xfer(16'h0000, 16, rx);
    chk("status", 16'h0001, rx);
    wfs_host_model_inst.xfer(16'h80f0, 16, rx);
    chk("status", 16'h0000, rx);
    chk("outs", 16'h00f0, {4'h0, outs});
    wfs_host_model_inst.xfer(16'h0000, 15, rx);
    chk("outs", 16'h00f0, {4'h0, outs});
    overVoltageSense = 1'b1;
    tick(6);
    chk("outs", 16'h0000, {4'h0, outs});
    chk("flag", 16'h0000, 16'(faultFlagOutput_b));
    overVoltageSense = 1'b0;
    tick(8);
    wfs_host_model_inst.xfer(16'h80f0, 16, rx);
    chk("status", 16'h0fff, {4'h0, rx[11:0]});
    wfs_host_model_inst.xfer(16'h80f0, 16, rx);
    chk("status", 16'h0000, {4'h0, rx[11:0]});
    // High driver 0 overheats: only it turns off, then it recovers.
    highsideDirectInputs = 4'h1;
    overTempSense = 12'h001;
    tick(6);
    chk("outs", 16'h00f0, {4'h0, outs});
    chk("flag", 16'h0000, 16'(faultFlagOutput_b));
    overTempSense = 12'h000;
    tick(6);
    chk("outs", 16'h00f1, {4'h0, outs});
    // Low driver 11 overheats: it stays off until commanded off.
    lowsideDirectInput = 1'b1;
    overTempSense = 12'h800;
    tick(6);
    chk("outs", 16'h07f1, {4'h0, outs});
    overTempSense = 12'h000;
    tick(6);
    chk("outs", 16'h07f1, {4'h0, outs});
    chk("flag", 16'h0000, 16'(faultFlagOutput_b));
    lowsideDirectInput = 1'b0;
    tick(6);
    chk("flag", 16'h0001, 16'(faultFlagOutput_b));
    lowsideDirectInput = 1'b1;
    tick(6);
    chk("outs", 16'h0ff1, {4'h0, outs});
    // Low driver 4 overcurrent shuts it down after the filter delay.
    lowsideDirectInput = 1'b0;
    wfs_host_model_inst.xfer(16'hd010, 16, rx);
    chk("status", 16'h0801, {4'h0, rx[11:0]});
    overCurrentSense = 8'h01;
    tick(200);
    chk("outs", 16'h00f1, {4'h0, outs});
    tick(100);
    chk("outs", 16'h00e1, {4'h0, outs});
    overCurrentSense = 8'h00;
    tick(6);
    chk("flag", 16'h0000, 16'(faultFlagOutput_b));
    wfs_host_model_inst.xfer(16'hd010, 16, rx);
    chk("status", 16'h0010, {4'h0, rx[11:0]});
    chk("failsafe", 16'h0000, 16'(failsafeActive));
    failsafeDisableInput = 1'b1;
    resetInput_b = 1'b0;
    tick(4);
    resetInput_b = 1'b1;
    lowsideDirectInput = 1'b1;
    highsideDirectInputs = 4'ha;
    repeat (4)
    begin
      tick(200);
      kickInput = ~kickInput;
    end
    chk("failsafe", 16'h0000, 16'(failsafeActive));
    waitFs(n);
    chk("fs delay", 16'h0001, 16'(n >= 250 && n <= 275));
    tick(4);
    chk("outs", 16'h0005, {4'h0, outs});
    resetInput_b = 1'b0;
    tick(6);
    chk("failsafe", 16'h0000, 16'(failsafeActive));
    tick(4);
    chk("outs", 16'h0000, {4'h0, outs});
    resetInput_b = 1'b1;
    tick(6);
    wfs_host_model_inst.xfer(16'he030, 16, rx);
    waitFs(n);
    chk("fs delay", 16'h0001, 16'(n >= 20 && n <= 40));
    // With wake high, reset low alone must not leave fail-safe.
    wakeInput = 1'b1;
    resetInput_b = 1'b0;
    tick(6);
    chk("failsafe", 16'h0001, 16'(failsafeActive));
    wakeInput = 1'b0;
    tick(6);
    chk("failsafe", 16'h0000, 16'(failsafeActive));
    wakeInput = 1'b1;
    waitFs(n);
    chk("fs delay", 16'h0001, 16'(n >= 250 && n <= 275));
    tick(4);
    chk("outs", 16'h0005, {4'h0, outs});
    tally_and_finish;
  end
endmodule
